//--- src/spcd_defines.svh
/*
  Shared constants of the single pin configuration decoder: timing, command codes,
  word field layout and register addresses.
  Assumes inclusion by bare name from the decoder sources and the test bench.
*/
`ifndef SPCD_DEFINES_SVH
`define SPCD_DEFINES_SVH

`define SPCD_CLK_PERIOD_NS 5
`define SPCD_NS_PER_MS 1000000
`define SPCD_SAMPLE_DELAY_NS 7143
`define SPCD_TIMEOUT_MS 16

`define SPCD_ENTRY_LAST 4'h5
`define SPCD_CMD_LAST 4'ha
`define SPCD_NUM_WORDS 6
`define SPCD_READBACK_EDGES 7'h3d

`define SPCD_ENTER_PROG 6'h0c
`define SPCD_ENTER_READBACK 6'h3b
`define SPCD_SEL_JUMP 3'h7
`define SPCD_JUMP_NOLOCK 8'hf0
`define SPCD_JUMP_LOCK 8'h55

`define SPCD_F_BAND 0
`define SPCD_F_ODIV_LO 1
`define SPCD_F_ODIV_HI 3
`define SPCD_F_PRE_LO 4
`define SPCD_F_PRE_HI 5

`define SPCD_WORD_RESET 8'h00
`define SPCD_CTRL_RESET 1'h1

`define SPCD_ADDR_STATUS 8'h00
`define SPCD_ADDR_CTRL 8'h04
`define SPCD_ADDR_SETTINGS 8'h08
`define SPCD_ADDR_WORD0 8'h10
`define SPCD_ADDR_WORD5 8'h24

`endif

//--- src/spcd_pkg.sv
/*
  Types of the single pin configuration decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spcd_pkg;
  typedef enum logic [4:0] {
    st_normal    = 5'h01,
    st_prog_idle = 5'h02,
    st_ee_nolock = 5'h04,
    st_ee_lock   = 5'h08,
    st_readback  = 5'h10
  } spcd_state_t;
endpackage

//--- src/spcd_bit_if.sv
/*
  Bit stream from the pulse sampler to the command decoder.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface spcd_bit_if;
  logic bit_valid;
  logic bit_value;
  logic pin_edge;
  modport tx (output bit_valid, output bit_value, output pin_edge);
  modport rx (input bit_valid, input bit_value, input pin_edge);
endinterface
`default_nettype wire

//--- src/spcd_bit_rx.sv
/*
  Pulse-code sampler: synchronises the programming pin and, a fixed delay after each
  rising edge, takes the pin level as the bit.
  Assumes an asynchronous pin and a 200 MHz core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spcd_defines.svh"
module spcd_bit_rx #(
  parameter int unsigned SAMPLE_CYCLES = (`SPCD_SAMPLE_DELAY_NS + `SPCD_CLK_PERIOD_NS - 1) / `SPCD_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic programming_pin,
  input wire logic enable,
  spcd_bit_if.tx bits
);
  localparam int CW = $clog2(SAMPLE_CYCLES + 1);
  logic sync1_q, sync2_q, level_q, busy_q;
  logic [CW-1:0] cnt_q;
  logic bit_valid_q, bit_value_q, edge_q;
  wire rise_w = sync2_q & ~level_q & enable;
  wire fire_w = busy_q && cnt_q == CW'(1);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 1'h0;
      sync2_q <= 1'h0;
      level_q <= 1'h0;
    end else begin
      sync1_q <= programming_pin;
      sync2_q <= sync1_q;
      level_q <= sync2_q;
    end
  end

  // Counter started at each rising edge strobes the pin after SAMPLE_CYCLES
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'h0;
      cnt_q <= '0;
    end else if (rise_w) begin
      busy_q <= 1'h1;
      cnt_q <= CW'(SAMPLE_CYCLES);
    end else if (busy_q) begin
      busy_q <= ~fire_w;
      cnt_q <= cnt_q - CW'(1);
    end
  end

  // One bit per rising edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_valid_q <= 1'h0;
      bit_value_q <= 1'h0;
      edge_q <= 1'h0;
    end else begin
      bit_valid_q <= fire_w;
      bit_value_q <= fire_w ? sync2_q : bit_value_q;
      edge_q <= (sync2_q ^ level_q) & enable;
    end
  end

  assign bits.bit_valid = bit_valid_q;
  assign bits.bit_value = bit_value_q;
  assign bits.pin_edge = edge_q;

  logic [CW:0] since_rise_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      since_rise_q <= '0;
    end else if (rise_w) begin
      since_rise_q <= '0;
    end else if (since_rise_q != '1) begin
      since_rise_q <= since_rise_q + (CW+1)'(1);
    end
  end

  AST_SAMPLE_DELAY: assert property (@(posedge core_clk) disable iff (!rstn)
    bit_valid_q |-> since_rise_q == (CW+1)'(SAMPLE_CYCLES))
    else $error("bit not sampled at the fixed delay after the rising edge");
endmodule
`default_nettype wire

//--- src/spcd_decoder.sv
/*
  Single pin configuration decoder: command state machine, six configuration words,
  effective synthesizer settings, EEPROM store requests and an APB register slave.
  Assumes an asynchronous programming pin, one 200 MHz clock and an APB master.
*/
// What this block does
// - Configuration enters only as writes on the pin; no read path there.
// - Read command puts the device in readback, flagged on readback_active.
// - Sequence 001100 moves normal operation to programming idle, else time-out.
// - Three-bit selector plus eight data bits writes configuration words 0 to 5.
// - One bit is latched per rising edge of the programming pin.
// - Long gaps between bits of a word write do not disturb it.
// - The completed word write latches the word; a word 0 write is applied at once.
// - Words live in working storage; word 0 is applied before any EEPROM save.
// - Jump 111 1111 0000 from idle stores to EEPROM without lock, if lock is not yet set.
// - Jump 111 0101 0101 from idle stores to EEPROM and sets lock, if lock is not yet set.
// - Jump 111 0000 0000 leaves EEPROM states for normal operation.
// - Any other 111 command returns the decoder to normal operation.
// - Feedback divider follows prescaler: 3 gives 20, 4 gives 16, 5 gives 12.
// - Word 0 selects oscillator band, output divider and prescaler.
// - Bits are pulse coded; a fixed delay after each rising edge samples the level.
// - During mode entry a pulse of 16 ms or more times out.
`timescale 1ns/10ps
`default_nettype none
`include "spcd_defines.svh"
module spcd_decoder #(
  parameter int unsigned TIMEOUT_CYCLES = (`SPCD_TIMEOUT_MS * `SPCD_NS_PER_MS + `SPCD_CLK_PERIOD_NS - 1) /
                                          `SPCD_CLK_PERIOD_NS,
  parameter int unsigned SAMPLE_CYCLES = (`SPCD_SAMPLE_DELAY_NS + `SPCD_CLK_PERIOD_NS - 1) / `SPCD_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic programming_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic upper_band_oscillator_sel,
  output logic [5:0] output_divider,
  output logic [2:0] prescaler,
  output logic [5:0] feedback_divider,
  output logic eeprom_store,
  output logic eeprom_lock,
  output logic readback_active
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  spcd_bit_if bits ();
  logic pin_enable_q;

  spcd_bit_rx #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_bit_rx (
    .core_clk(core_clk),
    .rstn(rstn),
    .programming_pin(programming_pin),
    .enable(pin_enable_q),
    .bits(bits)
  );

  spcd_pkg::spcd_state_t state_q, state_d;
  logic [10:0] shift_q;
  logic [3:0] cnt_q, cnt_d;
  logic [TW-1:0] idle_q;
  logic [6:0] rb_cnt_q;
  logic [7:0] configuration_word_q [`SPCD_NUM_WORDS];
  logic band_q, store_q, lock_q;
  logic [5:0] odiv_q, fb_q;
  logic [2:0] pre_q;

  // Command decode
  wire [10:0] cmd_w = {shift_q[9:0], bits.bit_value};
  wire in_normal_w = state_q == spcd_pkg::st_normal;
  wire in_prog_w = state_q == spcd_pkg::st_prog_idle;
  wire in_ee_w = state_q == spcd_pkg::st_ee_nolock || state_q == spcd_pkg::st_ee_lock;
  wire entry_done_w = in_normal_w && bits.bit_valid && cnt_q == `SPCD_ENTRY_LAST;
  wire cmd_done_w = (in_prog_w || in_ee_w) && bits.bit_valid && cnt_q == `SPCD_CMD_LAST;
  wire [2:0] sel_w = cmd_w[10:8];
  wire [7:0] data_w = cmd_w[7:0];
  // First selector bit sent is the index LSB
  wire [2:0] idx_w = {sel_w[0], sel_w[1], sel_w[2]};
  wire jump_w = cmd_done_w && sel_w == `SPCD_SEL_JUMP;
  wire word_wr_w = cmd_done_w && in_prog_w && sel_w != `SPCD_SEL_JUMP && idx_w < 3'(`SPCD_NUM_WORDS);
  wire to_nolock_w = jump_w && in_prog_w && data_w == `SPCD_JUMP_NOLOCK;
  wire to_lock_w = jump_w && in_prog_w && data_w == `SPCD_JUMP_LOCK;
  // Time-out applies to mode entry only; word writes may pause freely
  wire timeout_w = in_normal_w && cnt_q != 4'h0 && idle_q == TW'(TIMEOUT_CYCLES - 1);
  wire rb_done_w = state_q == spcd_pkg::st_readback && bits.bit_valid &&
                   rb_cnt_q == `SPCD_READBACK_EDGES - 7'h01;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      spcd_pkg::st_normal: begin
        if (entry_done_w && cmd_w[5:0] == `SPCD_ENTER_PROG) begin
          state_d = spcd_pkg::st_prog_idle;
        end else if (entry_done_w && cmd_w[5:0] == `SPCD_ENTER_READBACK) begin
          state_d = spcd_pkg::st_readback;
        end
      end
      spcd_pkg::st_prog_idle: begin
        if (to_nolock_w) begin
          state_d = spcd_pkg::st_ee_nolock;
        end else if (to_lock_w) begin
          state_d = spcd_pkg::st_ee_lock;
        end else if (jump_w) begin
          state_d = spcd_pkg::st_normal;
        end
      end
      spcd_pkg::st_ee_nolock, spcd_pkg::st_ee_lock: begin
        if (jump_w) begin
          state_d = spcd_pkg::st_normal;
        end
      end
      spcd_pkg::st_readback: begin
        if (rb_done_w) begin
          state_d = spcd_pkg::st_normal;
        end
      end
    endcase
  end

  // Partial entry sequences are dropped on time-out; a wrong entry code leaves state untouched
  always_comb begin
    cnt_d = cnt_q;
    if (timeout_w || entry_done_w || cmd_done_w || state_q == spcd_pkg::st_readback) begin
      cnt_d = 4'h0;
    end else if (bits.bit_valid) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= spcd_pkg::st_normal;
      cnt_q <= 4'h0;
      shift_q <= 11'h000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= bits.bit_valid ? cmd_w : shift_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idle_q <= '0;
    end else if (bits.pin_edge || cnt_q == 4'h0) begin
      idle_q <= '0;
    end else if (idle_q != TW'(TIMEOUT_CYCLES - 1)) begin
      idle_q <= idle_q + TW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rb_cnt_q <= 7'h00;
    end else if (state_q != spcd_pkg::st_readback) begin
      rb_cnt_q <= 7'h00;
    end else if (bits.bit_valid) begin
      rb_cnt_q <= rb_cnt_q + 7'h01;
    end
  end

  // Working storage, one word per entry
  genvar gi;
  generate
    for (gi = 0; gi < `SPCD_NUM_WORDS; gi++) begin : g_word
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          configuration_word_q[gi] <= `SPCD_WORD_RESET;
        end else if (word_wr_w && idx_w == 3'(gi)) begin
          configuration_word_q[gi] <= data_w;
        end
      end
    end
  endgenerate

  // Settings decode from word 0; codes 6 and 7 fall back to divide by one
  wire [2:0] odiv_code_w = data_w[`SPCD_F_ODIV_HI:`SPCD_F_ODIV_LO];
  wire [1:0] pre_code_w = data_w[`SPCD_F_PRE_HI:`SPCD_F_PRE_LO];
  wire [5:0] odiv_w = odiv_code_w > 3'h5 ? 6'h01 : 6'h01 << odiv_code_w;
  wire [2:0] pre_w = {1'h0, pre_code_w} + 3'h2;
  wire [5:0] fb_w = pre_w == 3'h3 ? 6'h14 : pre_w == 3'h4 ? 6'h10 : pre_w == 3'h5 ? 6'h0c : 6'h20;
  wire apply_w = word_wr_w && idx_w == 3'h0;

  // Applied at once, ahead of any save
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      band_q <= 1'h0;
      odiv_q <= 6'h01;
      pre_q <= 3'h2;
      fb_q <= 6'h20;
    end else if (apply_w) begin
      band_q <= data_w[`SPCD_F_BAND];
      odiv_q <= odiv_w;
      pre_q <= pre_w;
      fb_q <= fb_w;
    end
  end

  // Once locked, further store requests are refused
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      store_q <= 1'h0;
      lock_q <= 1'h0;
    end else begin
      store_q <= (to_nolock_w || to_lock_w) && !lock_q;
      lock_q <= lock_q | (to_lock_w && !lock_q);
    end
  end

  // APB slave, one access cycle, registered answer
  wire setup_w = psel && !penable;
  wire access_wr_w = psel && penable && pready && pwrite;
  wire [7:0] word_off_w = paddr - `SPCD_ADDR_WORD0;
  wire is_word_w = paddr >= `SPCD_ADDR_WORD0 && paddr <= `SPCD_ADDR_WORD5 && paddr[1:0] == 2'h0;
  wire mapped_w = paddr == `SPCD_ADDR_STATUS || paddr == `SPCD_ADDR_CTRL ||
                  paddr == `SPCD_ADDR_SETTINGS || is_word_w;
  wire [2:0] word_idx_w = word_off_w[4:2];
  wire [31:0] status_w = {23'h000000, lock_q, 3'h0, state_q};
  wire [31:0] settings_w = {10'h000, fb_q, 1'h0, pre_q, 2'h0, odiv_q, 3'h0, band_q};
  wire [31:0] rd_w = paddr == `SPCD_ADDR_STATUS ? status_w :
                     paddr == `SPCD_ADDR_CTRL ? {31'h00000000, pin_enable_q} :
                     paddr == `SPCD_ADDR_SETTINGS ? settings_w :
                     is_word_w ? {24'h000000, configuration_word_q[word_idx_w]} : 32'h00000000;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_w;
      pslverr <= setup_w && !mapped_w;
      prdata <= setup_w ? rd_w : prdata;
    end
  end

  // Words are not writable over the bus, so the pin stays the only config path
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_enable_q <= `SPCD_CTRL_RESET;
    end else if (access_wr_w && paddr == `SPCD_ADDR_CTRL) begin
      pin_enable_q <= pwdata[0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      readback_active <= 1'h0;
    end else begin
      readback_active <= state_d == spcd_pkg::st_readback;
    end
  end

  assign upper_band_oscillator_sel = band_q;
  assign output_divider = odiv_q;
  assign prescaler = pre_q;
  assign feedback_divider = fb_q;
  assign eeprom_store = store_q;
  assign eeprom_lock = lock_q;

  AST_ENTER_PROG: assert property (@(posedge core_clk) disable iff (!rstn)
    (entry_done_w && cmd_w[5:0] == `SPCD_ENTER_PROG) |=> state_q == spcd_pkg::st_prog_idle && cnt_q == 4'h0)
    else $error("entry code did not reach programming idle");

  AST_ENTER_READBACK: assert property (@(posedge core_clk) disable iff (!rstn)
    (entry_done_w && cmd_w[5:0] == `SPCD_ENTER_READBACK) |=> ##1 readback_active)
    else $error("readback code did not raise readback flag");

  AST_WORD_WRITE: assert property (@(posedge core_clk) disable iff (!rstn)
    word_wr_w |=> configuration_word_q[$past(idx_w)] == $past(data_w))
    else $error("word write not stored at its selector");

  AST_APPLY_NOW: assert property (@(posedge core_clk) disable iff (!rstn)
    (apply_w && !store_q) |=> band_q == $past(data_w[`SPCD_F_BAND]) && pre_q == $past(pre_w) && !store_q)
    else $error("word 0 setting not applied on the next edge");

  AST_FEEDBACK: assert property (@(posedge core_clk) disable iff (!rstn)
    (pre_q == 3'h3 && fb_q == 6'h14) || (pre_q == 3'h4 && fb_q == 6'h10) ||
    (pre_q == 3'h5 && fb_q == 6'h0c) || (pre_q == 3'h2 && fb_q == 6'h20))
    else $error("feedback divider does not follow prescaler");

  AST_JUMP_NOLOCK: assert property (@(posedge core_clk) disable iff (!rstn)
    to_nolock_w |=> state_q == spcd_pkg::st_ee_nolock && eeprom_store == !$past(lock_q) && lock_q == $past(lock_q))
    else $error("no-lock jump wrong");

  AST_JUMP_LOCK: assert property (@(posedge core_clk) disable iff (!rstn)
    to_lock_w |=> state_q == spcd_pkg::st_ee_lock && lock_q)
    else $error("lock jump did not set lock");

  AST_EXIT: assert property (@(posedge core_clk) disable iff (!rstn)
    (jump_w && !to_nolock_w && !to_lock_w) |=> in_normal_w)
    else $error("jump did not return to normal operation");

  AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (!rstn)
    timeout_w |=> cnt_q == 4'h0 && state_q == $past(state_q))
    else $error("time-out did not discard partial entry");

  AST_GAP_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    (!in_normal_w && !bits.bit_valid && state_q != spcd_pkg::st_readback) |=> $stable(cnt_q) && $stable(shift_q))
    else $error("gap disturbed a pending word write");

  AST_APB_ANSWER: assert property (@(posedge core_clk) disable iff (!rstn)
    setup_w |=> pready ##1 !pready || (psel && !penable))
    else $error("apb answer not one cycle after setup");

  AST_LOCK_REFUSE: assert property (@(posedge core_clk) disable iff (!rstn)
    ((to_nolock_w || to_lock_w) && lock_q) |=> !store_q && lock_q)
    else $error("store request passed although locked");

  AST_LOCK_STICKY: assert property (@(posedge core_clk) disable iff (!rstn)
    lock_q |=> lock_q)
    else $error("lock dropped without reset");

  AST_STORE_PULSE: assert property (@(posedge core_clk) disable iff (!rstn)
    store_q |=> !store_q)
    else $error("store request longer than one cycle");

  AST_READBACK_EXIT: assert property (@(posedge core_clk) disable iff (!rstn)
    rb_done_w |=> in_normal_w && !readback_active)
    else $error("readback did not end after its last edge");

  // Undefined selector must neither store nor leave idle
  AST_BAD_SEL: assert property (@(posedge core_clk) disable iff (!rstn)
    (cmd_done_w && in_prog_w && !jump_w && !word_wr_w) |=> in_prog_w && $stable(band_q))
    else $error("undefined selector changed state or settings");

  AST_APB_UNMAPPED: assert property (@(posedge core_clk) disable iff (!rstn)
    (setup_w && !mapped_w) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");

  COV_PROG: cover property (@(posedge core_clk) disable iff (!rstn) in_normal_w ##1 in_prog_w);
  COV_STORE_LOCK: cover property (@(posedge core_clk) disable iff (!rstn) to_lock_w);
  COV_READBACK_END: cover property (@(posedge core_clk) disable iff (!rstn) rb_done_w);
  COV_TIMEOUT: cover property (@(posedge core_clk) disable iff (!rstn) timeout_w);
  COV_STORE_NOLOCK: cover property (@(posedge core_clk) disable iff (!rstn) to_nolock_w && !lock_q);
endmodule
`default_nettype wire

//--- test/spcd_programmer.sv
/*
  Model of the external programmer that pulse-codes bits onto the programming pin.
  Assumes the decoder runs with a shortened sample delay; bit timing is in core_clk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module spcd_programmer #(
  parameter int BIT_CYCLES = 50,
  parameter int ZERO_HIGH = 10,
  parameter int ONE_HIGH = 40
) (
  input wire logic core_clk,
  output logic programming_pin
);
  // Pin rests low between frames
  initial programming_pin = 1'b0;

  // Scaled repeat rate; ratio of high time to bit period kept near 1/5 and 4/5
  task automatic send_bits(input logic [63:0] v, input int n);
    int hi;
    for (int k = n - 1; k >= 0; k--) begin
      hi = v[k] ? ONE_HIGH : ZERO_HIGH;
      @(posedge core_clk);
      programming_pin <= 1'b1;
      repeat (hi) @(posedge core_clk);
      programming_pin <= 1'b0;
      repeat (BIT_CYCLES - hi - 1) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
/*
  Self-checking bench of the configuration decoder: APB reads and pin commands.
  Assumes the decoder shortened to 2000 time-out and 20 sample cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spcd_defines.svh"
module tb;
  logic core_clk, rstn, psel, penable, pwrite, er, band, pready, pslverr, store, lock, rb;
  logic [7:0] paddr, w;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] odiv, fbd;
  logic [2:0] pre, s;
  wire logic pin;
  int bad_count, comparisons, store_cnt, cyc;

  spcd_programmer prog (.core_clk(core_clk), .programming_pin(pin));
  spcd_decoder #(.TIMEOUT_CYCLES(2000), .SAMPLE_CYCLES(20)) uut (
    .core_clk(core_clk), .rstn(rstn), .programming_pin(pin), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .upper_band_oscillator_sel(band), .output_divider(odiv), .prescaler(pre),
    .feedback_divider(fbd), .eeprom_store(store), .eeprom_lock(lock), .readback_active(rb));

  always #2.5 core_clk = ~core_clk;

  // Ceiling well above the roughly 24000 cycles the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (store === 1'b1) store_cnt++;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Waits for pready without a limit of its own; the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  // Expected synthesizer settings worked out from the field codes
  task automatic cfg(input int od, input int pr, input logic b);
    logic [5:0] fb;
    fb = (pr == 3) ? 6'h14 : (pr == 4) ? 6'h10 : (pr == 5) ? 6'h0c : 6'h20;
    check("band", {31'h0, band}, {31'h0, b});
    check("outdiv", {26'h0, odiv}, 32'h1 << od);
    check("prescaler", {29'h0, pre}, 32'(pr));
    check("feedback", {26'h0, fbd}, {26'h0, fb});
  endtask

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    cfg(0, 2, 1'b0);
    rdchk("status", `SPCD_ADDR_STATUS, 32'h1);
    rdchk("ctrl", `SPCD_ADDR_CTRL, 32'h1);
    apb(1'b0, 8'hfc, 32'h0);
    check("slverr", {31'h0, er}, 32'h1);
    check("slvdata", rd, 32'h0);
    // Pin ignored while disabled, and status is not writable
    apb(1'b1, `SPCD_ADDR_CTRL, 32'h0);
    prog.send_bits(`SPCD_ENTER_PROG, 6);
    rdchk("disabled", `SPCD_ADDR_STATUS, 32'h1);
    apb(1'b1, `SPCD_ADDR_CTRL, 32'h1);
    apb(1'b1, `SPCD_ADDR_STATUS, 32'h1f);
    rdchk("status_ro", `SPCD_ADDR_STATUS, 32'h1);
    prog.send_bits(6'h00, 6);
    rdchk("badentry", `SPCD_ADDR_STATUS, 32'h1);
    // Entry split by a long idle gap must not complete
    prog.send_bits(3'b001, 3);
    repeat (2500) @(posedge core_clk);
    prog.send_bits(3'b100, 3);
    rdchk("timeout", `SPCD_ADDR_STATUS, 32'h1);
    repeat (2500) @(posedge core_clk);
    prog.send_bits(`SPCD_ENTER_READBACK, 6);
    rdchk("readback", `SPCD_ADDR_STATUS, 32'h10);
    check("rb_on", {31'h0, rb}, 32'h1);
    prog.send_bits(64'h0, 61);
    rdchk("rb_exit", `SPCD_ADDR_STATUS, 32'h1);
    check("rb_off", {31'h0, rb}, 32'h0);
    prog.send_bits(`SPCD_ENTER_PROG, 6);
    rdchk("progidle", `SPCD_ADDR_STATUS, 32'h2);
    for (int i = 0; i < 6; i++) begin
      w = {2'b00, 2'(i % 4), 3'(i), 1'(i % 2)};
      prog.send_bits({3'b000, w}, 11);
      cfg(i, i % 4 + 2, 1'(i % 2));
      rdchk("word0", `SPCD_ADDR_WORD0, {24'h0, w});
    end
    for (int i = 1; i < 6; i++) begin
      s = {i[0], i[1], i[2]};
      w = 8'ha0 + 8'(i);
      prog.send_bits(s, 3);
      if (i == 3) repeat (2500) @(posedge core_clk);
      prog.send_bits(w, 8);
      rdchk("wordn", 8'(`SPCD_ADDR_WORD0 + 4 * i), {24'h0, w});
    end
    prog.send_bits({3'b011, 8'h5a}, 11);
    rdchk("badsel", `SPCD_ADDR_STATUS, 32'h2);
    rdchk("word0_kept", `SPCD_ADDR_WORD0, 32'h1b);
    cfg(5, 3, 1'b1);
    prog.send_bits({3'b111, 8'haa}, 11);
    rdchk("otherjump", `SPCD_ADDR_STATUS, 32'h1);
    check("nostore", 32'(store_cnt), 32'h0);
    prog.send_bits(`SPCD_ENTER_PROG, 6);
    prog.send_bits({`SPCD_SEL_JUMP, `SPCD_JUMP_NOLOCK}, 11);
    rdchk("ee_nolock", `SPCD_ADDR_STATUS, 32'h4);
    check("store1", 32'(store_cnt), 32'h1);
    check("nolock", {31'h0, lock}, 32'h0);
    // Scaled stand-in for the storage wait before the next jump
    repeat (200) @(posedge core_clk);
    prog.send_bits({3'b111, 8'h00}, 11);
    rdchk("exit1", `SPCD_ADDR_STATUS, 32'h1);
    prog.send_bits(`SPCD_ENTER_PROG, 6);
    prog.send_bits({`SPCD_SEL_JUMP, `SPCD_JUMP_LOCK}, 11);
    rdchk("ee_lock", `SPCD_ADDR_STATUS, 32'h108);
    check("store2", 32'(store_cnt), 32'h2);
    check("locked", {31'h0, lock}, 32'h1);
    repeat (200) @(posedge core_clk);
    prog.send_bits({3'b111, 8'h00}, 11);
    rdchk("exit2", `SPCD_ADDR_STATUS, 32'h101);
    cfg(5, 3, 1'b1);
    rdchk("settings", `SPCD_ADDR_SETTINGS, 32'h00143201);
    // Once locked, a further store jump moves state but sends no request
    prog.send_bits(`SPCD_ENTER_PROG, 6);
    prog.send_bits({`SPCD_SEL_JUMP, `SPCD_JUMP_NOLOCK}, 11);
    rdchk("relock", `SPCD_ADDR_STATUS, 32'h104);
    check("nostore2", 32'(store_cnt), 32'h2);
    repeat (200) @(posedge core_clk);
    prog.send_bits({3'b111, 8'h00}, 11);
    rdchk("exit3", `SPCD_ADDR_STATUS, 32'h101);
    summarize();
  end
endmodule
`default_nettype wire
